// ---- tb/reed_decoder_tb.sv ----
// bench for the enable decoder: host load, storage write, target reads
// assumes reed_target as the processor side; clk_en dropped once
`timescale 1ns/1ps
`default_nettype none
module reed_decoder_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic blk_en = 1'b0, dis_all = 1'b0, we = 1'b0, oe, doe, cyc;
   logic ce = 1'b1;
   logic [3:0] seg = 4'h0;
   logic [31:0] map = 32'h0;
   logic [19:0] waddr = 20'h0, baddr;
   logic [7:0] wdata = 8'h0, rdata, dout;
   int miscompares = 0, checks_done = 0;
   always #4 clk = ~clk;
   reed_decoder u_reed_decoder(.clk(clk), .sys_rst(sys_rst), .clk_en(ce),
      .emulation_block_enable(blk_en), .emulation_segment_select(seg),
      .cfg_map(map), .emulation_disable_all(dis_all), .mem_we(we),
      .mem_waddr(waddr), .mem_wdata(wdata), .bus_cycle(cyc),
      .bus_addr(baddr), .bus_data_out(dout), .bus_data_oe(doe));
   reed_target u_reed_target(.clk(clk), .bus_data_out(dout),
      .bus_data_oe(doe), .bus_cycle(cyc), .bus_addr(baddr));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // host transfer of segment and map, or a disable-all
   task automatic load(input logic [3:0] s, input logic [31:0] m,
      input logic clr);
      @(posedge clk);
      blk_en <= ~clr;
      dis_all <= clr;
      seg <= s;
      map <= m;
      @(posedge clk);
      blk_en <= 1'b0;
      dis_all <= 1'b0;
   endtask
   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge clk);
      we <= 1'b1;
      waddr <= a;
      wdata <= d;
      @(posedge clk);
      we <= 1'b0;
   endtask
   task automatic probe(input logic [19:0] a, input logic hit,
      input logic [7:0] d);
      u_reed_target.rd(a, rdata, oe);
      chk({7'h00, oe}, {7'h00, hit});
      if (hit) chk(rdata, d);
   endtask
   task automatic t_hits;
      wr(20'h00005, 8'hA5);
      wr(20'h00805, 8'h3C);
      load(4'hF, 32'h0001_000F, 1'b0);
      probe(20'hF0005, 1'b1, 8'hA5);
      probe(20'hE0005, 1'b0, 8'h00);
      probe(20'hF2005, 1'b0, 8'h00);
      probe(20'hF8005, 1'b1, 8'hA5);
      wr(20'h08123, 8'h5A);
      probe(20'hF0123, 1'b1, 8'h5A);
   endtask
   task automatic t_replace;
      load(4'hF, 32'h0000_0002, 1'b0);
      probe(20'hF0005, 1'b0, 8'h00);
      @(posedge clk);
      seg <= 4'hE;
      probe(20'hF0805, 1'b1, 8'h3C);
      load(4'hF, 32'h0000_0002, 1'b1);
      probe(20'hF0805, 1'b0, 8'h00);
   endtask
   // single-block and two-block loads, new segment, freeze, reset
   task automatic t_more;
      wr(20'h00FFF, 8'h69);
      load(4'hF, 32'h0000_0002, 1'b0);
      probe(20'hF0FFF, 1'b1, 8'h69);
      probe(20'hF1000, 1'b0, 8'h00);
      load(4'hF, 32'h0000_0003, 1'b0);
      probe(20'hF0005, 1'b1, 8'hA5);
      probe(20'hF0805, 1'b1, 8'h3C);
      load(4'hE, 32'h0000_0003, 1'b0);
      probe(20'hE0805, 1'b1, 8'h3C);
      probe(20'hF0805, 1'b0, 8'h00);
      @(posedge clk);
      ce <= 1'b0;
      probe(20'hE0005, 1'b0, 8'h00);
      @(posedge clk);
      ce <= 1'b1;
      probe(20'hE0005, 1'b1, 8'hA5);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      probe(20'hE0005, 1'b0, 8'h00);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      probe(20'hF0005, 1'b0, 8'h00);
      t_hits();
      t_replace();
      t_more();
      final_report();
   end
endmodule
`default_nettype wire

// ---- tb/reed_target.sv ----
// target bus model: one read per call, back to back allowed
// assumes the caller runs on rising edges of the shared clock
`timescale 1ns/1ps
`default_nettype none
module reed_target (
   input wire logic clk,
   input wire logic [7:0] bus_data_out,
   input wire logic bus_data_oe,
   output logic bus_cycle,
   output logic [19:0] bus_addr
);
   initial begin
      bus_cycle = 1'b0;
      bus_addr = 20'h00000;
   end
   // released address goes inverse so a stale value never looks valid
   task automatic rd(input logic [19:0] a, output logic [7:0] d,
      output logic oe);
      @(posedge clk);
      bus_cycle <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_cycle <= 1'b0;
      bus_addr <= ~a;
      #1;
      d = bus_data_out;
      oe = bus_data_oe;
   endtask
endmodule
`default_nettype wire

// ---- verilog/reed_decoder.sv ----
// rom emulation enable decoder with its 32K storage
// assumes target bus inputs synchronous to clk; host load port
`timescale 1ns/1ps
`default_nettype none
module reed_decoder (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // host side configuration transfer
   input wire logic emulation_block_enable,
   input wire logic [3:0] emulation_segment_select,
   input wire logic [31:0] cfg_map,
   input wire logic emulation_disable_all,
   // host side storage write
   input wire logic mem_we,
   input wire logic [19:0] mem_waddr,
   input wire logic [7:0] mem_wdata,
   // target bus
   input wire logic bus_cycle,
   input wire logic [19:0] bus_addr,
   output logic [7:0] bus_data_out,
   output logic bus_data_oe
);
   reed_pkg::reed_regs_t st_reg;
   reed_pkg::reed_regs_t st_next;
   logic [7:0] mem [0:reed_pkg::MEM_DEPTH-1];

   // segment field of a target address
   function automatic logic [3:0] seg_of(input logic [19:0] a);
      return a[reed_pkg::SEG_LSB +: 4];
   endfunction

   // map index of a target address, one entry per 2K block
   function automatic logic [4:0] blk_of(input logic [19:0] a);
      return a[reed_pkg::BLK_LSB +: 5];
   endfunction

   // true when the address falls in an enabled block of the stored segment
   function automatic logic hit(input reed_pkg::reed_cfg_t c,
                                input logic [19:0] a);
      logic seg_ok;
      seg_ok = (seg_of(a) == c.seg);
      return seg_ok && c.map[blk_of(a)];
   endfunction

   // storage index; modulo the size, so high windows alias low ones
   function automatic logic [14:0] midx(input logic [19:0] a);
      return a[reed_pkg::MEM_AW-1:0];
   endfunction

   // host writes to storage, not part of packed state to keep it small
   // modulo addressing
   always_ff @(posedge clk) begin
      if (clk_en && mem_we) begin
         mem[midx(mem_waddr)] <= mem_wdata;
      end
   end

   // next state
   always_comb begin
      st_next = st_reg;
      if (emulation_block_enable) begin
         st_next.cfg.seg = emulation_segment_select;
         st_next.cfg.map = cfg_map;
      end
      if (emulation_disable_all) begin
         st_next.cfg.map = reed_pkg::MAP_RESET;
      end
      st_next.data_oe = 1'b0;
      st_next.state = reed_pkg::REED_IDLE;
      if (bus_cycle && hit(st_reg.cfg, bus_addr)) begin
         st_next.state = reed_pkg::REED_ANSWER;
         st_next.data_oe = 1'b1;
         st_next.data_out = mem[midx(bus_addr)];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg.state <= reed_pkg::REED_IDLE;
         st_reg.cfg.seg <= reed_pkg::SEG_RESET;
         st_reg.cfg.map <= reed_pkg::MAP_RESET;
         st_reg.data_out <= reed_pkg::DATA_RESET;
         st_reg.data_oe <= 1'b0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   assign bus_data_out = st_reg.data_out;
   assign bus_data_oe = st_reg.data_oe;

   property p_answer;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && bus_cycle && hit(st_reg.cfg, bus_addr)
       && !emulation_block_enable && !emulation_disable_all)
      |=> bus_data_oe;
   endproperty
   a_answer: assert property (p_answer) else $error("hit not answered");

   property p_seg;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && bus_cycle && seg_of(bus_addr) != st_reg.cfg.seg)
      |=> !bus_data_oe;
   endproperty
   a_seg: assert property (p_seg) else $error("answer on wrong segment");

   property p_blk;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && !st_reg.cfg.map[blk_of(bus_addr)]) |=> !bus_data_oe;
   endproperty
   a_blk: assert property (p_blk) else $error("answer on disabled block");

   sequence s_clear;
      clk_en && emulation_disable_all && !emulation_block_enable;
   endsequence
   property p_clr;
      @(posedge clk) disable iff (sys_rst)
      s_clear |=> (st_reg.cfg.map == reed_pkg::MAP_RESET)
         ##1 (!$past(clk_en) || !bus_data_oe);
   endproperty
   a_clr: assert property (p_clr) else $error("answer after disable");

   property p_segld;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && emulation_block_enable)
      |=> st_reg.cfg.seg == $past(emulation_segment_select);
   endproperty
   a_segld: assert property (p_segld) else $error("segment not loaded");

   property p_seghold;
      @(posedge clk) disable iff (sys_rst)
      !emulation_block_enable |=> $stable(st_reg.cfg.seg);
   endproperty
   a_seghold: assert property (p_seghold) else $error("segment moved");

   property p_rst;
      @(posedge clk) $fell(sys_rst) |-> (st_reg.cfg.map == 32'h0000_0000)
         && !bus_data_oe;
   endproperty
   a_rst: assert property (p_rst) else $error("map not clear at reset");

   property p_alias;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && bus_cycle && hit(st_reg.cfg, bus_addr) && !mem_we)
      |=> bus_data_out == $past(mem[bus_addr[14:0]]);
   endproperty
   a_alias: assert property (p_alias) else $error("wrong data");

   // no answer without a taken cycle
   property p_idle;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && !bus_cycle) |=> !bus_data_oe;
   endproperty
   a_idle: assert property (p_idle) else $error("answer without cycle");

   property p_frz;
      @(posedge clk) disable iff (sys_rst)
      !clk_en |=> $stable(bus_data_oe) && $stable(bus_data_out);
   endproperty
   a_frz: assert property (p_frz) else $error("moved while frozen");

   // a load replaces the whole map
   property p_mapld;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && emulation_block_enable && !emulation_disable_all)
      |=> st_reg.cfg.map == $past(cfg_map);
   endproperty
   a_mapld: assert property (p_mapld) else $error("map not replaced");

   property p_maphold;
      @(posedge clk) disable iff (sys_rst)
      (!emulation_block_enable && !emulation_disable_all)
      |=> $stable(st_reg.cfg.map);
   endproperty
   a_maphold: assert property (p_maphold) else $error("map moved");

   // disable-all wins over the map of a same-cycle load, whose segment still loads
   property p_dis;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && emulation_disable_all)
      |=> st_reg.cfg.map == reed_pkg::MAP_RESET;
   endproperty
   a_dis: assert property (p_dis) else $error("map kept after disable");

   // a loaded segment stays until the next load
   sequence s_segload;
      clk_en && emulation_block_enable;
   endsequence
   sequence s_noload;
      !emulation_block_enable [*2];
   endsequence
   property p_segkeep;
      @(posedge clk) disable iff (sys_rst)
      s_segload ##1 s_noload
      |=> st_reg.cfg.seg == $past(emulation_segment_select, 3);
   endproperty
   a_segkeep: assert property (p_segkeep) else $error("segment lost");

   // quiet after release until a load
   sequence s_released;
      $fell(sys_rst);
   endsequence
   property p_quiet;
      @(posedge clk) disable iff (sys_rst)
      s_released ##0 (!emulation_block_enable [*2]) |=> !bus_data_oe;
   endproperty
   a_quiet: assert property (p_quiet) else $error("answer before load");

   // a write lands where its aliased window reads it back
   sequence s_write;
      clk_en && mem_we;
   endsequence
   property p_wralias;
      @(posedge clk) disable iff (sys_rst)
      s_write ##1 !mem_we
      ##1 (clk_en && bus_cycle && hit(st_reg.cfg, bus_addr) && !mem_we
         && midx(bus_addr) == midx($past(mem_waddr, 2)))
      |=> bus_data_out == $past(mem_wdata, 3);
   endproperty
   a_wralias: assert property (p_wralias) else $error("alias lost");
endmodule
`default_nettype wire

// ---- verilog/reed_pkg.sv ----
// constants and carriers for the rom emulation enable decoder
// assumes one 125 MHz clock and a host port that loads the map
//
// Contract
// - storage of 32K is addressed modulo its size, so 0 and 8000 alias.
// - address bits 19 to 16 are compared with the stored segment each cycle.
// - address bits 15 to 11 pick one map entry covering one 2K block.
// - data is driven only when segment matches and the picked entry is set.
// - after a disable-all the device answers no read or fetch until the next load.
package reed_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;
   localparam int MAP_N = 32;
   localparam int MEM_AW = 15;
   localparam int MEM_DEPTH = 32768;
   localparam int SEG_LSB = 16;
   localparam int BLK_LSB = 11;
   localparam logic [3:0] SEG_RESET = 4'h0;
   localparam logic [31:0] MAP_RESET = 32'h0000_0000;
   localparam logic [7:0] DATA_RESET = 8'h00;

   typedef enum logic [1:0] {
      REED_IDLE = 2'b01,
      REED_ANSWER = 2'b10
   } reed_state_t;

   typedef struct packed {
      logic [3:0] seg;
      logic [31:0] map;
   } reed_cfg_t;

   typedef struct packed {
      reed_state_t state;
      reed_cfg_t cfg;
      logic [7:0] data_out;
      logic data_oe;
   } reed_regs_t;
endpackage
